// *** hdl/mpr_pkg.sv ***
// constants shared by the center-aligned motor pwm with reload and sync
//
// How it works
// - counter ticks every mclk (fast source) or every third mclk (system rate).
// - modulus register sets the half period; 4800 gives 10 kHz at 96 MHz.
// - dead time in pwm ticks separates top and bottom of each pair; default 192.
// - every opportunity, no half-cycle: reload only at period start.
// - half-cycle reload on: reload at period start and at midpoint.
// - sync pulse only with a period-start reload, never at midpoint.
// - reload frequency change changes the sync rate with it.
// - reload every N opportunities, N from 1 to 16, independent of half-cycle.
// - per-pair polarity; negative top means low output turns the upper switch on.
// - protection input zero, active high at reset (fault polarity bit), disables its assigned outputs.
// - fault raises the interrupt only when its enable bit is set.
// - sync pulse drives the programmable delay trigger output.
package mpr_pkg;
	// ==========================================================
	// register offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_MOD  = 8'h04;
	localparam logic [7:0] ADDR_DEAD = 8'h08;
	localparam logic [7:0] ADDR_DUTY0 = 8'h0C;
	localparam logic [7:0] ADDR_DUTY1 = 8'h10;
	localparam logic [7:0] ADDR_DUTY2 = 8'h14;
	localparam logic [7:0] ADDR_FMAP = 8'h18;
	localparam logic [7:0] ADDR_STAT = 8'h1C;
	localparam logic [7:0] ADDR_CLR  = 8'h20;
	localparam logic [7:0] ADDR_IEN  = 8'h24;
	localparam logic [7:0] ADDR_CNTR = 8'h28;
	// ==========================================================
	// control register fields
	localparam int CTL_RUN        = 0;
	localparam int CTL_HALF       = 1;
	localparam int CTL_FREQ_LSB   = 2;
	localparam int CTL_FREQ_W     = 4;
	localparam int CTL_FAST       = 6;
	localparam int CTL_OUTEN      = 7;
	localparam int CTL_TOPNEG_LSB = 8;
	localparam int CTL_BOTNEG_LSB = 11;
	localparam int CTL_FLTPOL     = 14;
	// ==========================================================
	// status, clear and enable bit positions
	localparam int ST_FAULT  = 0;
	localparam int ST_RELOAD = 1;
	localparam int ST_SYNC   = 2;
	localparam int ST_W      = 3;
	// ==========================================================
	// reset values
	localparam logic [15:0] CTRL_RST = 16'h4740; // fast clock, top negative, fault high
	localparam logic [15:0] MOD_RST  = 16'h12C0; // 4800
	localparam logic [15:0] DEAD_RST = 16'h00C0; // 192
	localparam logic [15:0] DUTY_RST = 16'h0960; // 2400, half of the modulus
	localparam logic [15:0] FMAP_RST = 16'h003F; // all six outputs
	localparam logic [15:0] MOD_MIN  = 16'h0002;
	// ==========================================================
	// timing
	localparam int SLOW_DIV = 3; // system rate is a third of the fast source
endpackage : mpr_pkg

// *** hdl/mpr_dead_band.sv ***
// complementary pair generator with dead time
`timescale 1ns/1ps
`default_nettype none
module mpr_dead_band #(
	parameter int DW = 16
) (
	input  wire logic          mclk,
	input  wire logic          rst,
	input  wire logic          tick,
	input  wire logic          raw,
	input  wire logic [DW-1:0] dead,
	output logic               top_q,
	output logic               bot_q
);
	// a zero-width count could not hold any dead time
	if (DW < 1 || DW > 32) begin : g_bad_width
		$error("dead-time count width must be 1 to 32");
	end
	typedef struct packed {
		logic          cur;
		logic [DW-1:0] cnt;
		logic          top;
		logic          bot;
	} mpr_db_s;

	mpr_db_s s;
	mpr_db_s n;

	// ==========================================================
	// next state: both switches off for dead ticks after each edge
	always_comb begin
		n = s;
		if (tick) begin
			if (raw != s.cur) begin
				n.cur = raw;
				n.cnt = dead;
				n.top = raw && (dead == '0);
				n.bot = !raw && (dead == '0);
			end else if (s.cnt != '0) begin
				n.cnt = s.cnt - 1'b1;
				if (s.cnt == DW'(1)) begin
					n.top = s.cur;
					n.bot = !s.cur;
				end
			end
		end
	end

	// state register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s     <= '0;
			s.bot <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign top_q = s.top;
	assign bot_q = s.bot;

	// ==========================================================
	// checks
	a_dead_overlap: assert property (@(posedge mclk) disable iff (rst)
		!(s.top && s.bot)) else $error("top and bottom on together");
	a_dead_wait: assert property (@(posedge mclk) disable iff (rst)
		$rose(s.top) && (dead != '0) |-> $past(!s.bot)) else $error("top on without gap");
endmodule : mpr_dead_band
`default_nettype wire

// *** hdl/mpr_pwm.sv ***
// center-aligned six-output motor pwm with reload, sync and fault protection
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module mpr_pwm #(
	parameter int CW = 16
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	input  wire logic        protection_input_zero,
	output logic      [5:0]  pwm_out,
	output logic             reload_event,
	output logic             programmable_delay_trigger,
	output logic             irq
);
	// ==========================================================
	// elaboration check
	if (CW < 13 || CW > 16) begin : g_bad_width
		$error("counter width must hold 4800 and fit the 16-bit registers");
	end
	// the tick divider is two bits wide
	if (mpr_pkg::SLOW_DIV < 2 || mpr_pkg::SLOW_DIV > 4) begin : g_bad_div
		$error("slow tick divider must be 2 to 4");
	end

	typedef struct packed {
		logic                sy1;   // first synchroniser stage
		logic                sy2;
		logic [1:0]          div;
		logic                tick;
		logic [CW-1:0]       cnt;
		logic                down;
		logic [3:0]          ropp;
		logic [15:0]         ctrl;
		logic [CW-1:0]       mod_sh;
		logic [CW-1:0]       mod_act;
		logic [CW-1:0]       dead;
		logic [2:0][CW-1:0]  duty_sh;
		logic [2:0][CW-1:0]  duty_act;
		logic [5:0]          fmap;
		logic                flt;
		logic [2:0]          st;
		logic [2:0]          en;
		logic [5:0]          pwm;
		logic                irq;
		logic                reload;
		logic                sync;
		logic [31:0]         rdata;
	} mpr_state_s;

	mpr_state_s s;
	mpr_state_s n;

	logic       run;
	logic       start_ev;
	logic       mid_ev;
	logic       opp;
	logic       rel;
	logic       fa;
	logic [2:0] raw;
	logic [2:0] clr;
	logic [2:0] top;
	logic [2:0] bot;

	// ==========================================================
	// compare: active while cnt is within duty of the turning point
	function automatic logic above(input logic [CW-1:0] c, input logic [CW-1:0] d,
		input logic [CW-1:0] m);
		return ({1'b0, c} + {1'b0, d}) > {1'b0, m};
	endfunction : above

	// ==========================================================
	// dead-time pairs
	for (genvar i = 0; i < 3; i++) begin : g_pair
		mpr_dead_band #(.DW(CW)) u_db (
			.mclk  (mclk),
			.rst   (rst),
			.tick  (s.tick),
			.raw   (raw[i]),
			.dead  (s.dead),
			.top_q (top[i]),
			.bot_q (bot[i])
		);
	end

	// ==========================================================
	// next state
	always_comb begin
		n        = s;
		run      = s.ctrl[mpr_pkg::CTL_RUN];
		start_ev = s.tick && run && !s.down && (s.cnt == '0);
		mid_ev   = s.tick && run && !s.down && (s.cnt >= s.mod_act);
		opp      = start_ev || (mid_ev && s.ctrl[mpr_pkg::CTL_HALF]);
		rel      = opp && (s.ropp >= s.ctrl[mpr_pkg::CTL_FREQ_LSB +: mpr_pkg::CTL_FREQ_W]);
		fa       = (s.sy2 == s.ctrl[mpr_pkg::CTL_FLTPOL]);
		clr      = '0;
		for (int i = 0; i < 3; i++) begin
			raw[i] = run && (s.duty_act[i] != '0) && above(s.cnt, s.duty_act[i], s.mod_act);
		end

		// fault pin synchroniser
		// only the second stage is read; a pulse under one clock may be lost
		n.sy1 = protection_input_zero;
		n.sy2 = s.sy1;

		// pwm tick divider: fast source every clock, else every third
		// the tick is a one-cycle enable, so everything stays on mclk
		if (s.ctrl[mpr_pkg::CTL_FAST]) begin
			n.div  = '0;
			n.tick = 1'b1;
		end else begin
			n.div  = (s.div == 2'(mpr_pkg::SLOW_DIV - 1)) ? 2'd0 : s.div + 1'b1;
			n.tick = (s.div == 2'(mpr_pkg::SLOW_DIV - 1));
		end

		// up/down counter
		// the down slope restarts at mod - 1 so one period is exactly 2 * mod ticks
		if (!run) begin
			n.cnt  = '0;
			n.down = 1'b0;
			n.ropp = '0;
		end else if (s.tick) begin
			if (!s.down) begin
				if (s.cnt >= s.mod_act) begin
					n.down = 1'b1;
					n.cnt  = s.mod_act - 1'b1;
				end else begin
					n.cnt = s.cnt + 1'b1;
				end
			end else begin
				n.cnt = s.cnt - 1'b1;
				if (s.cnt == CW'(1)) begin
					n.down = 1'b0;
				end
			end
		end

		// reload opportunity counter
		if (opp) begin
			n.ropp = rel ? 4'd0 : s.ropp + 1'b1;
		end

		// buffered values load only on reload; modulus only at period start
		// a modulus change mid-period would leave the two halves unequal
		if (rel) begin
			n.duty_act = s.duty_sh;
			if (start_ev) begin
				n.mod_act = (s.mod_sh < CW'(mpr_pkg::MOD_MIN)) ? CW'(mpr_pkg::MOD_MIN) : s.mod_sh;
			end
		end
		n.reload = rel;
		n.sync   = rel && start_ev;

		// fault latch clears at a period start once the input is quiet
		if (fa) begin
			n.flt = 1'b1;
		end else if (start_ev || !run) begin
			n.flt = 1'b0;
		end

		// register writes
		if (wr) begin
			case (addr)
				mpr_pkg::ADDR_CTRL: begin
					n.ctrl = wdata[15:0];
				end
				mpr_pkg::ADDR_MOD: begin
					n.mod_sh = wdata[CW-1:0];
				end
				mpr_pkg::ADDR_DEAD: begin
					n.dead = wdata[CW-1:0];
				end
				mpr_pkg::ADDR_DUTY0: begin
					n.duty_sh[0] = wdata[CW-1:0];
				end
				mpr_pkg::ADDR_DUTY1: begin
					n.duty_sh[1] = wdata[CW-1:0];
				end
				mpr_pkg::ADDR_DUTY2: begin
					n.duty_sh[2] = wdata[CW-1:0];
				end
				mpr_pkg::ADDR_FMAP: begin
					n.fmap = wdata[5:0];
				end
				mpr_pkg::ADDR_CLR: begin
					clr = wdata[mpr_pkg::ST_W-1:0];
				end
				mpr_pkg::ADDR_IEN: begin
					n.en = wdata[mpr_pkg::ST_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// sticky status: a new event beats a clear in the same cycle
		n.st = s.st & ~clr;
		n.st[mpr_pkg::ST_FAULT]  = n.st[mpr_pkg::ST_FAULT] | fa;
		n.st[mpr_pkg::ST_RELOAD] = n.st[mpr_pkg::ST_RELOAD] | rel;
		n.st[mpr_pkg::ST_SYNC]   = n.st[mpr_pkg::ST_SYNC] | (rel && start_ev);
		n.irq = |(n.st & n.en);

		// outputs: gate by enable and fault, then apply pair polarity
		for (int i = 0; i < 3; i++) begin
			n.pwm[2*i] = top[i] && s.ctrl[mpr_pkg::CTL_OUTEN] && !(s.flt && s.fmap[2*i]);
			n.pwm[2*i+1] = bot[i] && s.ctrl[mpr_pkg::CTL_OUTEN] && !(s.flt && s.fmap[2*i+1]);
			n.pwm[2*i] = n.pwm[2*i] ^ s.ctrl[mpr_pkg::CTL_TOPNEG_LSB + i];
			n.pwm[2*i+1] = n.pwm[2*i+1] ^ s.ctrl[mpr_pkg::CTL_BOTNEG_LSB + i];
		end

		// read data stand only in the cycle after the strobe
		n.rdata = '0;
		if (rd) begin
			case (addr)
				mpr_pkg::ADDR_CTRL:  n.rdata = {16'h0000, s.ctrl};
				mpr_pkg::ADDR_MOD:   n.rdata = 32'(s.mod_sh);
				mpr_pkg::ADDR_DEAD:  n.rdata = 32'(s.dead);
				mpr_pkg::ADDR_DUTY0: n.rdata = 32'(s.duty_sh[0]);
				mpr_pkg::ADDR_DUTY1: n.rdata = 32'(s.duty_sh[1]);
				mpr_pkg::ADDR_DUTY2: n.rdata = 32'(s.duty_sh[2]);
				mpr_pkg::ADDR_FMAP:  n.rdata = {26'h000_0000, s.fmap};
				mpr_pkg::ADDR_STAT:  n.rdata = {29'h0000_0000, s.st};
				mpr_pkg::ADDR_IEN:   n.rdata = {29'h0000_0000, s.en};
				mpr_pkg::ADDR_CNTR:  n.rdata = {s.sy2, s.flt, s.down, 13'h0000, 16'(s.cnt)};
				default:             n.rdata = '0;
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s            <= '0;
			s.tick       <= mpr_pkg::CTRL_RST[mpr_pkg::CTL_FAST]; // matches the reset rate
			s.ctrl       <= mpr_pkg::CTRL_RST;
			s.mod_sh     <= CW'(mpr_pkg::MOD_RST);
			s.mod_act    <= CW'(mpr_pkg::MOD_RST);
			s.dead       <= CW'(mpr_pkg::DEAD_RST);
			s.duty_sh    <= {3{CW'(mpr_pkg::DUTY_RST)}};
			s.duty_act   <= {3{CW'(mpr_pkg::DUTY_RST)}};
			s.fmap       <= mpr_pkg::FMAP_RST[5:0];
			s.pwm        <= 6'h15; // tops negative: all switches off
		end else begin
			s <= n;
		end
	end

	assign rdata                      = s.rdata;
	assign pwm_out                    = s.pwm;
	assign reload_event               = s.reload;
	assign programmable_delay_trigger = s.sync;
	assign irq                        = s.irq;

	// ==========================================================
	// checks
	a_sync_with_reload: assert property (@(posedge mclk) disable iff (rst)
		s.sync |-> s.reload) else $error("sync without reload");
	a_mid_no_sync: assert property (@(posedge mclk) disable iff (rst)
		s.reload && s.down |-> !s.sync) else $error("sync at midpoint");
	a_reload_no_half: assert property (@(posedge mclk) disable iff (rst)
		s.reload && !$past(s.ctrl[mpr_pkg::CTL_HALF]) |-> s.sync) else $error("midpoint reload");
	a_fault_blocks: assert property (@(posedge mclk) disable iff (rst)
		s.flt && s.fmap[0] |=> pwm_out[0] == $past(s.ctrl[mpr_pkg::CTL_TOPNEG_LSB]))
		else $error("faulted output driven");
	a_irq_fault: assert property (@(posedge mclk) disable iff (rst)
		s.st[mpr_pkg::ST_FAULT] && s.en[mpr_pkg::ST_FAULT] |-> irq) else $error("fault irq lost");
	a_duty_hold: assert property (@(posedge mclk) disable iff (rst)
		$changed(s.duty_act) |-> s.reload) else $error("duty changed without reload");
	a_count_bound: assert property (@(posedge mclk) disable iff (rst)
		s.cnt <= s.mod_act) else $error("counter past modulus");
	a_fast_tick: assert property (@(posedge mclk) disable iff (rst)
		s.ctrl[mpr_pkg::CTL_FAST] && $past(s.ctrl[mpr_pkg::CTL_FAST]) |-> s.tick)
		else $error("fast source missed a tick");

	// half-cycle reload at every opportunity reloads at the midpoint, without sync
	a_half_mid: assert property (@(posedge mclk) disable iff (rst)
		s.tick && s.ctrl[mpr_pkg::CTL_RUN] && !s.down && (s.cnt >= s.mod_act)
		&& s.ctrl[mpr_pkg::CTL_HALF]
		&& (s.ctrl[mpr_pkg::CTL_FREQ_LSB +: mpr_pkg::CTL_FREQ_W] == 4'h0)
		|=> reload_event && !programmable_delay_trigger)
		else $error("midpoint reload missing");

	// every period start at one reload per opportunity fires the delay trigger
	a_start_sync: assert property (@(posedge mclk) disable iff (rst)
		s.tick && s.ctrl[mpr_pkg::CTL_RUN] && !s.down && (s.cnt == '0)
		&& (s.ctrl[mpr_pkg::CTL_FREQ_LSB +: mpr_pkg::CTL_FREQ_W] == 4'h0)
		|=> reload_event && programmable_delay_trigger)
		else $error("period start without sync");

	// a stopped counter raises no reload
	a_stop_quiet: assert property (@(posedge mclk) disable iff (rst)
		!s.ctrl[mpr_pkg::CTL_RUN] |=> !reload_event) else $error("reload while stopped");

	// an active synchronised fault pin latches the fault and its status bit
	a_fault_latch: assert property (@(posedge mclk) disable iff (rst)
		(s.sy2 == s.ctrl[mpr_pkg::CTL_FLTPOL]) |=> s.flt && s.st[mpr_pkg::ST_FAULT])
		else $error("fault not latched");

	// the modulus in use never drops below the floor
	a_mod_floor: assert property (@(posedge mclk) disable iff (rst)
		s.mod_act >= CW'(mpr_pkg::MOD_MIN)) else $error("modulus below floor");

	// at the system rate ticks never come on two clocks in a row
	a_slow_tick: assert property (@(posedge mclk) disable iff (rst)
		!s.ctrl[mpr_pkg::CTL_FAST] && s.tick |=> !s.tick)
		else $error("slow tick too fast");
endmodule : mpr_pwm
`default_nettype wire

// *** testbench/mpr_gate_drv.sv ***
// three-phase gate pre-driver model watching the six pwm pins
`timescale 1ns/1ps
`default_nettype none
module mpr_gate_drv (
	input  wire logic        mclk,
	input  wire logic        watch,
	input  wire logic [5:0]  gate,
	output logic      [31:0] min_off,
	output logic      [31:0] overlap
);
	int mo = 32'h7FFF_FFFF;
	int ov = 0;
	int off_run [3] = '{-99999, -99999, -99999};
	assign min_off = 32'(mo);
	assign overlap = 32'(ov);
	// ==========================================================
	// per leg: upper switch on while its input is low, lower while high
	always @(posedge mclk) begin
		for (int i = 0; i < 3; i++) begin
			if (!watch) begin
				off_run[i] = -99999; // first gap after watch starts is partial
			end else if (gate[2*i] && !gate[2*i+1]) begin
				off_run[i]++;
			end else begin
				if (!gate[2*i] && gate[2*i+1]) ov++;
				if (off_run[i] > 0 && off_run[i] < mo) mo = off_run[i];
				off_run[i] = 0;
			end
		end
	end
endmodule : mpr_gate_drv
`default_nettype wire

// *** testbench/mpr_pwm_test.sv ***
// self-checking bench for the center-aligned motor pwm
`timescale 1ns/1ps
`default_nettype none
module mpr_pwm_test;
	localparam int M  = 20;
	localparam int DT = 2;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        flt = 1'b0;
	logic        watch = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata, min_off, overlap, d;
	logic [31:0] seed = 32'h0001_52B2;
	logic [5:0]  pwm_out;
	logic        reload_event, sync, irq;
	int          err_total = 0;
	int          comparisons = 0;
	logic [7:0]  ra [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
		8'h20, 8'h24, 8'h28};
	logic [15:0] rv [11] = '{mpr_pkg::CTRL_RST, mpr_pkg::MOD_RST, mpr_pkg::DEAD_RST,
		mpr_pkg::DUTY_RST, mpr_pkg::DUTY_RST, mpr_pkg::DUTY_RST, mpr_pkg::FMAP_RST,
		16'h0000, 16'h0000, 16'h0000, 16'h0000};
	int          hf [5] = '{0, 0, 1, 1, 0};
	int          nn [5] = '{1, 2, 1, 3, 1};
	int          fs [5] = '{1, 1, 1, 1, 0};

	// ==========================================================
	// clock and instances
	always #5 mclk = ~mclk;

	mpr_pwm dut_u (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .protection_input_zero(flt), .pwm_out(pwm_out),
		.reload_event(reload_event), .programmable_delay_trigger(sync), .irq(irq));
	mpr_gate_drv drv_u (.mclk(mclk), .watch(watch), .gate(pwm_out), .min_off(min_off),
		.overlap(overlap));

	// ==========================================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	function automatic logic [31:0] ctl(input int half, n, fast, tn, bn);
		return 32'h0000_4081 | 32'(half << mpr_pkg::CTL_HALF)
			| 32'((n - 1) << mpr_pkg::CTL_FREQ_LSB) | 32'(fast << mpr_pkg::CTL_FAST)
			| 32'(tn << mpr_pkg::CTL_TOPNEG_LSB) | 32'(bn << mpr_pkg::CTL_BOTNEG_LSB);
	endfunction : ctl

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task wreg(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wreg

	task rreg(input logic [7:0] a);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rreg

	// gap in clocks from a sync to the next reload and the next sync
	task measure(input int rl, input int sy);
		int t, tr, ts;
		t = 0;
		tr = 0;
		ts = 0;
		while (sync !== 1'b1 && t < 5000) begin
			@(posedge mclk);
			#1 t++;
		end
		t = 0;
		while (ts == 0 && t < 5000) begin
			@(posedge mclk);
			#1 t++;
			if (reload_event === 1'b1 && tr == 0) tr = t;
			if (sync === 1'b1) ts = t;
			if (sync === 1'b1 && reload_event !== 1'b1) chk("lone sync", 0, 1);
		end
		chk("reload gap", tr, rl);
		chk("sync gap", ts, sy);
	endtask : measure

	task results;
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results

	// ==========================================================
	// watchdog
	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		results();
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		#1 chk("idle pins", {26'h0, pwm_out}, 32'h0000_0015);
		for (int i = 0; i < 11; i++) begin
			rreg(ra[i]);
			chk("reset value", d, {16'h0000, rv[i]});
		end
		wreg(8'h04, M);
		wreg(8'h08, DT);
		// all legs start at half duty before the outputs are enabled
		for (int i = 0; i < 3; i++) begin
			wreg(8'h0C + 8'(4 * i), M / 2);
		end
		watch <= 1'b1;
		// reload frequency, half-cycle and clock rate table; legs 1 and 2 then go random
		for (int i = 0; i < 5; i++) begin
			wreg(8'h00, ctl(hf[i], nn[i], fs[i], 7, 0) & 32'hFFFF_FFFE);
			wreg(8'h00, ctl(hf[i], nn[i], fs[i], 7, 0));
			measure(nn[i] * (hf[i] ? M : 2 * M) * (fs[i] ? 1 : 3),
				2 * nn[i] * M * (fs[i] ? 1 : 3));
			seed = xs(seed);
			wreg(8'h10 + 8'(4 * (i % 2)), 2 + seed % (M - 3));
		end
		chk("dead time", min_off, DT);
		rreg(8'h1C);
		chk("event status", d, 32'h0000_0006);
		chk("shoot through", overlap, 0);
		watch <= 1'b0;
		// fault with random output polarity, masked then enabled interrupt
		for (int i = 0; i < 3; i++) begin
			seed = xs(seed);
			wreg(8'h00, ctl(0, 1, 1, int'(seed[2:0]), int'(seed[5:3])));
			wreg(8'h24, 0);
			@(posedge mclk);
			flt <= 1'b1;
			repeat (8) @(posedge mclk);
			#1 chk("fault pins", {26'h0, pwm_out},
				{26'h0, seed[5], seed[2], seed[4], seed[1], seed[3], seed[0]});
			chk("irq masked", {31'h0, irq}, 0);
			rreg(8'h1C);
			chk("fault status", {31'h0, d[0]}, 1);
			wreg(8'h24, 1);
			repeat (3) @(posedge mclk);
			#1 chk("irq raised", {31'h0, irq}, 1);
			@(posedge mclk);
			flt <= 1'b0;
			repeat (6) @(posedge mclk);
			wreg(8'h20, 7);
			repeat (3) @(posedge mclk);
			#1 chk("irq cleared", {31'h0, irq}, 0);
		end
		results();
	end
endmodule : mpr_pwm_test
`default_nettype wire
